// >>> core/fsq_bus_cycle.sv
`timescale 1ns/1ns
`default_nettype none
module fsq_bus_cycle (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request
  input wire logic start,
  input wire logic wr,
  input wire logic [fsq_pkg::AW-1:0] addr,
  input wire logic [fsq_pkg::DW-1:0] wdata,
  output logic done,
  output logic [fsq_pkg::DW-1:0] rdata,
  // flash pins
  output logic [fsq_pkg::AW-1:0] fl_addr,
  output logic [fsq_pkg::DW-1:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [fsq_pkg::DW-1:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n
);
  import fsq_pkg::*;

  typedef enum logic [2:0] {
    CY_IDLE = 3'b000, CY_SETUP = 3'b001, CY_PULSE = 3'b011, CY_HOLD = 3'b010,
    CY_RWAIT = 3'b110
  } fsq_cy_e;

  typedef struct packed {
    fsq_cy_e st;
    logic [3:0] cnt;
    logic wr;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic dq_oe;
    logic [AW-1:0] addr;
    logic [DW-1:0] dq_o;
    logic [DW-1:0] s1;
    logic [DW-1:0] s2;
    logic [DW-1:0] s3;
    logic [DW-1:0] rdata;
    logic done;
  } fsq_cy_s;

  fsq_cy_s r, n;

  // one write or read cycle; address and data held steady around the strobe
  always_comb begin
    n = r;
    n.done = 1'b0;
    n.s1 = fl_dq_i;
    n.s2 = r.s1;
    n.s3 = r.s2;
    case (r.st)
      CY_IDLE: begin
        if (start) begin
          n.st = CY_SETUP;
          n.wr = wr;
          n.addr = addr;
          n.dq_o = wdata;
          n.dq_oe = wr;
          n.ce_n = 1'b0;
          n.cnt = '0;
        end
      end
      CY_SETUP: begin
        // address is latched by the device on the later falling strobe
        if (r.wr) begin
          n.we_n = 1'b0;
          n.st = CY_PULSE;
        end else begin
          n.oe_n = 1'b0;
          n.st = CY_RWAIT;
        end
      end
      CY_PULSE: begin
        n.cnt = r.cnt + 4'd1;
        if (r.cnt == 4'(WP_CYC - 1)) begin
          n.we_n = 1'b1; // data taken on this rising edge
          n.st = CY_HOLD;
        end
      end
      CY_HOLD: begin
        n.ce_n = 1'b1;
        n.dq_oe = 1'b0;
        n.done = 1'b1;
        n.st = CY_IDLE;
      end
      CY_RWAIT: begin
        // access time plus the sync depth, then only a settled value counts
        if (r.cnt != 4'(ACC_CYC + 2)) begin
          n.cnt = r.cnt + 4'd1;
        end else if (r.s2 == r.s3) begin
          n.rdata = r.s3;
          n.oe_n = 1'b1;
          n.ce_n = 1'b1;
          n.done = 1'b1;
          n.st = CY_IDLE;
        end
      end
      default: n.st = CY_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: CY_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  assign done = r.done;
  assign rdata = r.rdata;
  assign fl_addr = r.addr;
  assign fl_dq_o = r.dq_o;
  assign fl_dq_oe = r.dq_oe;
  assign fl_ce_n = r.ce_n;
  assign fl_we_n = r.we_n;
  assign fl_oe_n = r.oe_n;
endmodule // fsq_bus_cycle
`default_nettype wire

// >>> core/fsq_host.sv
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module fsq_host (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash pins
  output logic [fsq_pkg::AW-1:0] fl_addr,
  output logic [fsq_pkg::DW-1:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [fsq_pkg::DW-1:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  output logic fl_reset_n,
  output logic fl_width_n,
  input wire logic ready_busy_n
);
  import fsq_pkg::*;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000, HS_SEQ = 3'b001, HS_WINDOW = 3'b011, HS_POLL = 3'b010,
    HS_HWRST = 3'b110
  } fsq_hs_e;

  typedef struct packed {
    fsq_hs_e st;
    fsq_op_e op;
    logic [2:0] idx;
    logic issued;
    logic [9:0] cnt;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic byte_mode;
    logic in_bypass;
    logic in_ssr;
    logic refused;
    logic to_err;
    logic v_err;
    logic [DW-1:0] rdata;
    logic [31:0] prdata;
    logic start;
    logic cyc_wr;
    logic [AW-1:0] cyc_addr;
    logic [DW-1:0] cyc_wdata;
    logic rst_n;
    logic s1;
    logic s2;
    logic s3;
    logic rdy;
  } fsq_hs_s;

  fsq_hs_s r, n;
  logic cyc_done;
  logic [DW-1:0] cyc_rdata;
  logic [7:0] status;
  logic cmd_wr;
  logic ok;
  logic [1:0] ak;
  logic [7:0] sd;
  logic [2:0] slen;

  // sequence table: address kind and data code of each step
  function automatic logic [12:0] seq_step(input fsq_op_e op, input logic [2:0] i);
    logic [12:0] s;
    s = {3'd1, AK_U1, D_RESET};
    case (op)
      OP_PROG: case (i)
        3'd0: s = {3'd4, AK_U1, D_UNLK1};
        3'd1: s = {3'd4, AK_U2, D_UNLK2};
        3'd2: s = {3'd4, AK_U1, D_PROG};
        default: s = {3'd4, AK_USER_DATA, D_ZERO};
      endcase
      OP_CHIP, OP_SECT: case (i)
        3'd0, 3'd3: s = {3'd6, AK_U1, D_UNLK1};
        3'd1, 3'd4: s = {3'd6, AK_U2, D_UNLK2};
        3'd2: s = {3'd6, AK_U1, D_ERASE};
        default: s = (op == OP_CHIP) ? {3'd6, AK_U1, D_CHIP} : {3'd6, AK_USER, D_SECT};
      endcase
      OP_SECT_ADD: s = {3'd1, AK_USER, D_SECT};
      OP_BYP_ENTER, OP_SSR_ENTER: case (i)
        3'd0: s = {3'd3, AK_U1, D_UNLK1};
        3'd1: s = {3'd3, AK_U2, D_UNLK2};
        default: s = {3'd3, AK_U1, (op == OP_SSR_ENTER) ? D_SSR : D_BYP};
      endcase
      OP_BYP_PROG: s = (i == 3'd0) ? {3'd2, AK_U1, D_PROG} : {3'd2, AK_USER_DATA, D_ZERO};
      OP_BYP_EXIT: s = (i == 3'd0) ? {3'd2, AK_U1, D_EXIT} : {3'd2, AK_U1, D_ZERO};
      OP_SSR_EXIT: case (i)
        3'd0: s = {3'd4, AK_U1, D_UNLK1};
        3'd1: s = {3'd4, AK_U2, D_UNLK2};
        3'd2: s = {3'd4, AK_U1, D_EXIT};
        default: s = {3'd4, AK_U1, D_ZERO};
      endcase
      OP_READ: s = {3'd1, AK_USER, D_ZERO}; // array read at the user address
      default: s = {3'd1, AK_U1, D_RESET};
    endcase
    return s;
  endfunction

  assign {slen, ak, sd} = seq_step(r.op, r.idx);
  assign cmd_wr = psel && penable && pwrite && (paddr == REG_CMD);

  // which operations the host may launch in its present mode
  always_comb begin
    ok = 1'b0;
    case (r.st)
      HS_IDLE: begin
        if (r.in_bypass) begin
          ok = pwdata[3:0] inside {OP_BYP_PROG, OP_BYP_EXIT, OP_READ};
        end else begin
          ok = (pwdata[3:0] <= 4'(OP_READ)) && (pwdata[3:0] != 4'(OP_SECT_ADD)) &&
               !(r.in_ssr && pwdata[3:0] == 4'(OP_BYP_ENTER));
        end
      end
      HS_WINDOW: ok = pwdata[3:0] inside {OP_SECT_ADD, OP_RESET};
      default: ok = 1'b0;
    endcase
    if (pwdata[3:0] == 4'(OP_HWRST)) begin
      ok = 1'b1;
    end
  end

  assign status = {r.v_err, r.to_err, r.refused, (r.st == HS_WINDOW), r.in_ssr, r.in_bypass,
                   r.rdy, (r.st != HS_IDLE)};

  // main sequencer
  always_comb begin
    n = r;
    n.start = 1'b0;
    // ready pin: three flops, accepted once the last two agree
    n.s1 = ready_busy_n;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3) begin
      n.rdy = r.s3;
    end
    // apb read data is built in the setup phase so the access needs no wait
    if (psel && !penable && !pwrite) begin
      case (paddr)
        REG_ADDR: n.prdata = 32'(r.addr);
        REG_DATA: n.prdata = 32'(r.data);
        REG_CFG: n.prdata = 32'(r.byte_mode);
        REG_STATUS: n.prdata = 32'(status);
        REG_RDATA: n.prdata = 32'(r.rdata);
        default: n.prdata = 32'h0000_0000;
      endcase
    end
    // the address stays writable in the erase window so further sectors can be queued
    if (psel && penable && pwrite &&
        (r.st == HS_IDLE || (r.st == HS_WINDOW && paddr == REG_ADDR))) begin
      case (paddr)
        REG_ADDR: n.addr = pwdata[AW-1:0];
        REG_DATA: n.data = pwdata[DW-1:0];
        REG_CFG: n.byte_mode = pwdata[CFG_BYTE_POS];
        default: n.addr = r.addr;
      endcase
    end
    case (r.st)
      HS_SEQ: begin
        if (!r.issued) begin
          n.start = 1'b1;
          n.issued = 1'b1;
          n.cyc_wr = (r.op != OP_READ);
          n.cyc_wdata = (ak == AK_USER_DATA) ? r.data : DW'(sd);
          case (ak)
            AK_U1: n.cyc_addr = r.byte_mode ? UNLK1_B : UNLK1_W;
            AK_U2: n.cyc_addr = r.byte_mode ? UNLK2_B : UNLK2_W;
            default: n.cyc_addr = r.addr;
          endcase
        end else if (cyc_done) begin
          n.issued = 1'b0;
          n.cnt = '0;
          if (r.op == OP_READ) begin
            n.rdata = cyc_rdata;
            n.st = HS_IDLE;
          end else if (r.idx != slen - 3'd1) begin
            n.idx = r.idx + 3'd1;
          end else begin
            n.st = HS_IDLE;
            case (r.op)
              OP_PROG, OP_BYP_PROG, OP_CHIP: n.st = HS_POLL;
              OP_SECT, OP_SECT_ADD: n.st = HS_WINDOW;
              OP_BYP_ENTER: n.in_bypass = 1'b1;
              OP_BYP_EXIT: n.in_bypass = 1'b0;
              OP_SSR_ENTER: n.in_ssr = 1'b1;
              OP_SSR_EXIT: n.in_ssr = 1'b0;
              default: n.st = HS_IDLE;
            endcase
          end
        end
      end
      HS_WINDOW: begin
        // counted from the end of the last write strobe
        n.cnt = r.cnt + 10'd1;
        if (r.cnt == 10'(WIN_CYC - 1)) begin
          n.st = HS_POLL;
          n.cnt = '0;
        end
      end
      HS_POLL: begin
        // wait for the device to drop ready before trusting the pin
        if (r.cnt != 10'(BUSY_CYC)) begin
          n.cnt = r.cnt + 10'd1;
        end else if (!r.issued) begin
          n.start = 1'b1;
          n.issued = 1'b1;
          n.cyc_wr = 1'b0;
          n.cyc_addr = r.addr;
        end else if (cyc_done) begin
          n.issued = 1'b0;
          n.rdata = cyc_rdata;
          if (r.rdy) begin
            n.st = HS_IDLE;
            if ((r.op == OP_PROG || r.op == OP_BYP_PROG) &&
                (r.byte_mode ? cyc_rdata[7:0] != r.data[7:0] : cyc_rdata != r.data)) begin
              n.v_err = 1'b1;
            end
          end else if (cyc_rdata[TIMEOUT_ERR_POS]) begin
            n.to_err = 1'b1;
            n.op = OP_RESET;
            n.idx = '0;
            n.st = HS_SEQ;
          end
        end
      end
      HS_HWRST: begin
        n.cnt = r.cnt + 10'd1;
        if (r.cnt == 10'(RP_CYC - 1)) begin
          n.rst_n = 1'b1;
        end
        if (r.cnt == 10'(RP_CYC + RH_CYC - 1)) begin
          n.st = HS_IDLE;
          n.cnt = '0;
        end
      end
      default: n.st = HS_IDLE;
    endcase
    // launching an operation; a refusal sets the sticky flag last so it wins
    if (cmd_wr) begin
      if (ok && !(r.issued && pwdata[3:0] == 4'(OP_HWRST) && !cyc_done)) begin
        n.op = fsq_op_e'(pwdata[3:0]);
        n.idx = '0;
        n.cnt = '0;
        n.issued = 1'b0;
        n.refused = 1'b0;
        n.to_err = 1'b0;
        n.v_err = 1'b0;
        if (pwdata[3:0] == 4'(OP_HWRST)) begin
          n.st = HS_HWRST;
          n.start = 1'b0; // no strobe cycle may launch into the reset pulse
          n.rst_n = 1'b0;
          n.in_bypass = 1'b0;
          n.in_ssr = 1'b0;
        end else begin
          n.st = HS_SEQ;
        end
      end else begin
        n.refused = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: HS_IDLE, op: OP_RESET, rst_n: 1'b1, byte_mode: CFG_RESET, s1: 1'b1, s2: 1'b1,
             s3: 1'b1, rdy: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  // one strobe generator for every command write and status read
  fsq_bus_cycle u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .start(r.start),
    .wr(r.cyc_wr),
    .addr(r.cyc_addr),
    .wdata(r.cyc_wdata),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe),
    .fl_dq_i(fl_dq_i),
    .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n)
  );

  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr inside {REG_ADDR, REG_DATA, REG_CFG, REG_CMD,
                   REG_STATUS, REG_RDATA});
  assign fl_reset_n = r.rst_n;
  assign fl_width_n = !r.byte_mode;
endmodule // fsq_host
`default_nettype wire

// >>> core/fsq_pkg.sv
package fsq_pkg;
  // clock and timing, each time in its own unit, cycles derived from it
  localparam int CLK_NS = 100;
  localparam int T_WP_NS = 35;
  localparam int T_ACC_NS = 55;
  localparam int T_BUSY_NS = 90;
  localparam int T_RP_NS = 500;
  localparam int T_RH_NS = 50;
  localparam int T_WIN_US = 50;
  // least times round up, the erase window (a longest time) rounds down
  localparam int WP_CYC = ((T_WP_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = ((T_ACC_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_CYC = ((T_BUSY_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : (T_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC = ((T_RP_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RH_CYC = ((T_RH_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : (T_RH_NS + CLK_NS - 1) / CLK_NS;
  localparam int WIN_CYC = (T_WIN_US * 1000) / CLK_NS;
  // flash pin widths
  localparam int AW = 20;
  localparam int DW = 16;
  // unlock addresses per width
  localparam logic [AW-1:0] UNLK1_W = 20'h00555;
  localparam logic [AW-1:0] UNLK2_W = 20'h002AA;
  localparam logic [AW-1:0] UNLK1_B = 20'h00AAA;
  localparam logic [AW-1:0] UNLK2_B = 20'h00555;
  // command data codes
  localparam logic [7:0] D_UNLK1 = 8'hAA;
  localparam logic [7:0] D_UNLK2 = 8'h55;
  localparam logic [7:0] D_PROG = 8'hA0;
  localparam logic [7:0] D_ERASE = 8'h80;
  localparam logic [7:0] D_CHIP = 8'h10;
  localparam logic [7:0] D_SECT = 8'h30;
  localparam logic [7:0] D_SSR = 8'h88;
  localparam logic [7:0] D_BYP = 8'h20;
  localparam logic [7:0] D_EXIT = 8'h90;
  localparam logic [7:0] D_ZERO = 8'h00;
  localparam logic [7:0] D_RESET = 8'hF0;
  // status bit positions on the data bus
  localparam int DATA_POLL_POS = 7;
  localparam int TOGGLE_POS = 6;
  localparam int TIMEOUT_ERR_POS = 5;
  localparam int ERASE_TIMER_POS = 3;
  localparam int ALT_TOGGLE_POS = 2;
  // apb register byte offsets
  localparam logic [7:0] REG_ADDR = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_CFG = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam int CFG_BYTE_POS = 0;
  localparam logic CFG_RESET = 1'b0;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_READY = 1;
  localparam int ST_BYPASS = 2;
  localparam int ST_SSR = 3;
  localparam int ST_WINDOW = 4;
  localparam int ST_REFUSED = 5;
  localparam int ST_TOERR = 6;
  localparam int ST_VERR = 7;
  // operations written to the command register
  typedef enum logic [3:0] {
    OP_PROG = 4'h0, OP_CHIP = 4'h1, OP_SECT = 4'h2, OP_SECT_ADD = 4'h3,
    OP_BYP_ENTER = 4'h4, OP_BYP_PROG = 4'h5, OP_BYP_EXIT = 4'h6,
    OP_SSR_ENTER = 4'h7, OP_SSR_EXIT = 4'h8, OP_RESET = 4'h9,
    OP_HWRST = 4'hA, OP_READ = 4'hB
  } fsq_op_e;
  // address kind of a sequence step
  typedef enum logic [1:0] {
    AK_U1 = 2'h0, AK_U2 = 2'h1, AK_USER_DATA = 2'h2, AK_USER = 2'h3
  } fsq_ak_e;
endpackage

// >>> testbench/fsq_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module fsq_flash_model #(
  parameter int PROG_US = 8,
  parameter int ERASE_US = 12,
  parameter logic [15:0] SERIAL_BASE = 16'h5A00 // arbitrary value
) (
  // host pins
  input wire logic [fsq_pkg::AW-1:0] fl_addr,
  input wire logic [15:0] fl_dq_o,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n,
  input wire logic fl_reset_n,
  input wire logic fl_width_n,
  // device outputs
  output logic [15:0] fl_dq_i,
  output logic ready_busy_n
);
  import fsq_pkg::*;
  logic [15:0] mem [256];
  logic [15:0] p_d = 16'hFFFF, rd, rd_q = 16'h0;
  logic [AW-1:0] a_lat = '0, p_a = '0;
  logic [15:0] sect = 16'h0; // one bit per sixteen-word sector
  logic byp = 1'h0, ssr = 1'h0, tgl = 1'h0, pend = 1'h0;
  int n = 0, busy = 0, win = 0;
  wire [AW-1:0] u1 = fl_width_n ? UNLK1_W : UNLK1_B;
  wire [AW-1:0] u2 = fl_width_n ? UNLK2_W : UNLK2_B;
  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  // address on the later fall of strobe or select
  always @(negedge fl_we_n or negedge fl_ce_n) if (!fl_we_n && !fl_ce_n) a_lat = fl_addr;
  // data on the first rise, which the host always makes on the strobe
  always @(posedge fl_we_n) if (!fl_ce_n && fl_oe_n && fl_reset_n) wr(a_lat, fl_dq_o);
  task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
    if (busy > 0) return;
    if (win > 0) begin
      if (d[7:0] == D_SECT) begin sect[a[7:4]] = 1'h1; win = T_WIN_US; end
      else begin win = 0; sect = 16'h0; end
    end else if (d[7:0] == D_RESET) n = 0;
    else if (byp) begin
      if (n == 0 && d[7:0] == D_PROG) n = 1;
      else if (n == 0 && d[7:0] == D_EXIT) n = 2;
      else if (n == 1) begin p_a = a; p_d = d; pend = 1'h1; busy = PROG_US; n = 0; end
      else begin
        if (n == 2 && d[7:0] == D_ZERO) byp = 1'h0;
        n = 0;
      end
    end else case (n)
      0: n = (a == u1 && d[7:0] == D_UNLK1) ? 1 : 0;
      1: n = (a == u2 && d[7:0] == D_UNLK2) ? 2 : 0;
      2: begin
        n = (a != u1) ? 0 : (d[7:0] == D_PROG) ? 3 : (d[7:0] == D_ERASE) ? 4 : 0;
        if (a == u1 && d[7:0] == D_EXIT) n = 7;
        if (a == u1 && d[7:0] == D_SSR) ssr = 1'h1;
        if (a == u1 && d[7:0] == D_BYP) byp = !ssr;
      end
      3: begin p_a = a; p_d = d; pend = 1'h1; busy = PROG_US; n = 0; end
      4: n = (a == u1 && d[7:0] == D_UNLK1) ? 5 : 0;
      5: n = (a == u2 && d[7:0] == D_UNLK2) ? 6 : 0;
      6: begin
        n = 0;
        p_d = 16'hFFFF;
        if (a == u1 && d[7:0] == D_CHIP) begin sect = 16'hFFFF; busy = ERASE_US; end
        if (d[7:0] == D_SECT) begin sect[a[7:4]] = 1'h1; win = T_WIN_US; end
      end
      7: begin if (d[7:0] == D_ZERO) ssr = 1'h0; n = 0; end
      default: n = 0;
    endcase
  endtask
  // algorithms and the erase window run on a 1 us tick, independent of the host clock
  always #1000 begin
    if (win > 0) begin
      win = win - 1;
      if (win == 0) busy = ERASE_US;
    end else if (busy > 0) begin
      busy = busy - 1;
      if (busy == 0) begin
        if (pend) mem[p_a[7:0]] = mem[p_a[7:0]] & p_d;
        foreach (mem[i]) if (sect[i >> 4]) mem[i] = 16'hFFFF;
        pend = 1'h0;
        sect = 16'h0;
      end
    end
  end
  // hardware reset drops any running algorithm and every mode
  always @(negedge fl_reset_n) begin
    busy = 0; win = 0; n = 0; byp = 1'h0; ssr = 1'h0; pend = 1'h0; sect = 16'h0;
  end
  // status while working, array or serial number otherwise
  always @* begin
    rd = ssr ? (SERIAL_BASE | {8'h0, fl_addr[7:0]}) : mem[fl_addr[7:0]];
    if (busy > 0 || win > 0) begin
      rd = 16'h0;
      rd[DATA_POLL_POS] = ~p_d[7];
      rd[TOGGLE_POS] = tgl;
      rd[ALT_TOGGLE_POS] = tgl & (sect != 16'h0);
      rd[ERASE_TIMER_POS] = (win == 0);
    end
  end
  always @(negedge fl_oe_n) if (busy > 0 || win > 0) tgl = ~tgl;
  // a released bus shows the inverse of the last value, never a stale copy
  always @(posedge fl_oe_n) rd_q = rd;
  assign fl_dq_i = (!fl_ce_n && !fl_oe_n) ? rd : ~rd_q;
  assign ready_busy_n = (busy == 0);
endmodule // fsq_flash_model
`default_nettype wire

// >>> testbench/fsq_host_bench.sv
`timescale 1ns/1ns
`default_nettype none
module fsq_host_bench;
  import fsq_pkg::*;
  localparam logic [15:0] SN = 16'h5A00; // arbitrary serial pattern
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, lo;
  logic [AW-1:0] fl_addr;
  logic [DW-1:0] fl_dq_o, fl_dq_i;
  logic fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_reset_n, fl_width_n, ready_busy_n;
  int num_errors = 0;
  int checks = 0;
  fsq_host i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
    .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
    .fl_reset_n(fl_reset_n), .fl_width_n(fl_width_n), .ready_busy_n(ready_busy_n));
  fsq_flash_model #(.SERIAL_BASE(SN)) i_flash (.fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
    .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_reset_n(fl_reset_n),
    .fl_width_n(fl_width_n), .fl_dq_i(fl_dq_i), .ready_busy_n(ready_busy_n));
  always #50 pclk = ~pclk;
  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0; penable <= 1'h0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic op(input fsq_op_e o, input logic [19:0] a, input logic [15:0] d);
    apb(1'h1, REG_ADDR, {12'h0, a});
    apb(1'h1, REG_DATA, {16'h0, d});
    apb(1'h1, REG_CMD, {28'h0, o});
  endtask
  // poll a status bit; bounded so a stuck design falls to the comparisons
  task automatic poll(input int b, input logic v);
    for (int i = 0; i < 4000; i++) begin
      apb(1'h0, REG_STATUS, 32'h0);
      if (rd[ST_READY] === 1'h0) lo = 1'h1;
      if (rd[b] === v && rd[ST_WINDOW] === 1'h0) break;
    end
  endtask
  task automatic run(input fsq_op_e o, input logic [19:0] a, input logic [15:0] d);
    lo = 1'h0;
    op(o, a, d);
    poll(ST_BUSY, 1'h0);
  endtask
  task automatic rdv(input logic [19:0] a, input logic [31:0] e);
    run(OP_READ, a, 16'h0);
    apb(1'h0, REG_RDATA, 32'h0);
    chk(rd, e);
  endtask
  task automatic t_reset();
    chk({29'h0, fl_reset_n, fl_ce_n, fl_we_n}, 32'h7);
    apb(1'h0, REG_STATUS, 32'h0);
    chk(rd, 32'h2);
    apb(1'h0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'h1, REG_CFG, 32'h1);
    apb(1'h0, REG_CFG, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, fl_width_n}, 32'h0);
    run(OP_PROG, 20'h8, 16'h0055);
    rdv(20'h8, 32'h0055);
    apb(1'h1, REG_CFG, 32'h0);
    $display("reset and registers done");
  endtask
  task automatic t_program();
    run(OP_PROG, 20'h5, 16'h1234);
    chk({31'h0, lo}, 32'h1);
    rdv(20'h5, 32'h1234);
    run(OP_PROG, 20'h5, 16'hFF00);
    apb(1'h0, REG_STATUS, 32'h0);
    chk({31'h0, rd[ST_VERR]}, 32'h1);
    rdv(20'h5, 32'h1200);
    $display("program done");
  endtask
  task automatic t_bypass();
    run(OP_BYP_ENTER, 20'h0, 16'h0);
    run(OP_BYP_PROG, 20'h6, 16'h00AB);
    run(OP_BYP_PROG, 20'h7, 16'h0CD0);
    apb(1'h1, REG_CMD, {28'h0, OP_CHIP});
    apb(1'h0, REG_STATUS, 32'h0);
    chk({30'h0, rd[ST_REFUSED], rd[ST_BYPASS]}, 32'h3);
    run(OP_BYP_EXIT, 20'h0, 16'h0);
    chk({31'h0, rd[ST_BYPASS]}, 32'h0);
    rdv(20'h6, 32'h00AB);
    rdv(20'h7, 32'h0CD0);
    $display("bypass done");
  endtask
  task automatic t_secure();
    run(OP_SSR_ENTER, 20'h0, 16'h0);
    apb(1'h1, REG_CMD, {28'h0, OP_BYP_ENTER});
    apb(1'h0, REG_STATUS, 32'h0);
    chk({30'h0, rd[ST_REFUSED], rd[ST_SSR]}, 32'h3);
    rdv(20'h1, {16'h0, SN | 16'h1});
    run(OP_SSR_EXIT, 20'h0, 16'h0);
    chk({31'h0, rd[ST_SSR]}, 32'h0);
    rdv(20'h1, 32'hFFFF);
    $display("secured region done");
  endtask
  task automatic t_erase();
    run(OP_PROG, 20'h25, 16'h0);
    op(OP_SECT, 20'h5, 16'h0);
    for (int i = 0; i < 100 && rd[ST_WINDOW] !== 1'h1; i++) apb(1'h0, REG_STATUS, 32'h0);
    chk({31'h0, rd[ST_WINDOW]}, 32'h1);
    run(OP_SECT_ADD, 20'h25, 16'h0);
    rdv(20'h5, 32'hFFFF);
    rdv(20'h25, 32'hFFFF);
    run(OP_PROG, 20'h30, 16'h0);
    op(OP_SECT, 20'h30, 16'h0);
    for (int i = 0; i < 100 && rd[ST_WINDOW] !== 1'h1; i++) apb(1'h0, REG_STATUS, 32'h0);
    run(OP_RESET, 20'h0, 16'h0);
    rdv(20'h30, 32'h0);
    run(OP_CHIP, 20'h0, 16'h0);
    chk({31'h0, lo}, 32'h1);
    rdv(20'h6, 32'hFFFF);
    $display("erase done");
  endtask
  task automatic t_hwrst();
    op(OP_PROG, 20'h40, 16'h0);
    poll(ST_READY, 1'h0);
    repeat (4) begin
      apb(1'h1, REG_CMD, {28'h0, OP_HWRST});
      apb(1'h0, REG_STATUS, 32'h0);
      if (rd[ST_REFUSED] === 1'h0) break;
    end
    poll(ST_BUSY, 1'h0);
    chk(rd & 32'h7, 32'h2);
    rdv(20'h40, 32'hFFFF);
    run(OP_PROG, 20'h40, 16'h0F0F);
    rdv(20'h40, 32'h0F0F);
    $display("hardware reset done");
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_program();
    t_bypass();
    t_secure();
    t_erase();
    t_hwrst();
    results();
  end
  // watchdog well beyond the expected run of some two thousand cycles
  initial begin
    repeat (80000) @(posedge pclk);
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    results();
  end
endmodule // fsq_host_bench
bind fsq_host fsq_host_chk i_chk (.pclk(pclk), .presetn(presetn), .fl_addr(fl_addr),
  .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
  .fl_reset_n(fl_reset_n), .fl_width_n(fl_width_n), .ready_busy_n(ready_busy_n));
`default_nettype wire

// >>> testbench/fsq_host_sva.sv
`timescale 1ns/1ns
`default_nettype none
module fsq_host_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // flash pins
  input wire logic [fsq_pkg::AW-1:0] fl_addr,
  input wire logic fl_dq_oe,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n,
  input wire logic fl_reset_n,
  input wire logic fl_width_n,
  input wire logic ready_busy_n
);
  import fsq_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // write strobe sits one cycle inside a three-cycle select
  wr_strobe_a:
    assert property ($fell(fl_we_n) |-> !$past(fl_ce_n) ##1 (fl_we_n && !fl_ce_n) ##1 fl_ce_n)
    else $error("write strobe out of shape");
  // a write needs select low, output enable high and the data bus driven
  wr_inhibit_a:
    assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe) else $error("bad write");
  // reads never fight the flash on the data bus
  rd_excl_a:
    assert property (!fl_oe_n |-> !fl_ce_n && fl_we_n && !fl_dq_oe) else $error("bad read");
  // address must not move while the flash may still latch it
  addr_hold_a:
    assert property (!fl_ce_n && !$past(fl_ce_n) |-> $stable(fl_addr)) else $error("addr moved");
  width_hold_a:
    assert property (!fl_ce_n && !$past(fl_ce_n) |-> $stable(fl_width_n)) else $error("width");
  // hardware reset pulse is five cycles long
  hwrst_len_a:
    assert property ($fell(fl_reset_n) |-> !fl_reset_n [*5] ##1 fl_reset_n)
    else $error("reset pulse length wrong");
  hwrst_quiet_a:
    assert property (!fl_reset_n |-> fl_ce_n && fl_we_n) else $error("access during reset");
  // once busy is seen through the synchroniser no new write may start
  busy_quiet_a:
    assert property (!ready_busy_n && !$past(ready_busy_n) && !$past(ready_busy_n, 2)
      && !$past(ready_busy_n, 3) |-> !$fell(fl_we_n)) else $error("write while busy");
  cover property ($fell(fl_reset_n));
  cover property (!ready_busy_n ##1 ready_busy_n);
  cover property ($fell(fl_oe_n));
endmodule // fsq_host_chk
`default_nettype wire
